// file: pkg/instr_decode_pkg.sv
/*
  Constants, field layouts and carrier types for the instruction format decoder.
  Assumes a single synchronous core clock and a fetch stage that delivers whole words.
*/
// Contract
// RQ1: Each instruction is one 32-bit word on a word-aligned address.
// RQ2: Three layouts: immediate, jump, register; operation code in bits 31:26.
// RQ3: Immediate and register layouts carry source bits 25:21, target bits 20:16.
// RQ4: Immediate layout carries a 16-bit constant in the low bits.
// RQ5: Register layout: destination 15:11, shift 10:6, function 5:0; jump target 25:0.
// RQ6: Loads and stores address as base plus sign-extended 16-bit displacement.
// RQ7: A use of the loaded register right after a load stalls the pipeline.
// RQ8: Access size comes only from the operation code.
// RQ9: The effective address names the lowest-order byte of the item.
// RQ10: Big endian puts byte 0 at bits 31:24, little endian at bits 7:0.
// RQ11: Lanes follow size and low three address bits within the permitted set.
// RQ12: Any other size and offset pairing raises an address error, no access.
// RQ13: Computation uses two registers, or one register and a 16-bit constant.
// RQ14: Multiplies go to a separate multiplier; product lands in high and low.
// RQ15: Moves from high or low stall until the product is available.
package instr_decode_pkg;

    localparam int          WORD_W      = 32;
    localparam int          OPC_MSB     = 31;
    localparam int          OPC_LSB     = 26;
    localparam int          SRC_MSB     = 25;
    localparam int          SRC_LSB     = 21;
    localparam int          TGT_MSB     = 20;
    localparam int          TGT_LSB     = 16;
    localparam int          DST_MSB     = 15;
    localparam int          DST_LSB     = 11;
    localparam int          SHF_MSB     = 10;
    localparam int          SHF_LSB     = 6;
    localparam int          FUN_MSB     = 5;
    localparam int          IMM_MSB     = 15;
    localparam int          JMP_MSB     = 25;
    localparam logic [1:0]  ALIGN_BITS  = 2'h0;
    localparam int          MUL_LAT_DEF = 4;

    // Operation codes are parameters of the classification only; values are plain defaults.
    localparam logic [5:0]  OPC_SPECIAL = 6'h00;
    localparam logic [5:0]  OPC_JUMP    = 6'h02;
    localparam logic [5:0]  OPC_JLINK   = 6'h03;
    localparam logic [5:0]  OPC_LB      = 6'h20;
    localparam logic [5:0]  OPC_LH      = 6'h21;
    localparam logic [5:0]  OPC_LT      = 6'h22;
    localparam logic [5:0]  OPC_LW      = 6'h23;
    localparam logic [5:0]  OPC_SB      = 6'h28;
    localparam logic [5:0]  OPC_SH      = 6'h29;
    localparam logic [5:0]  OPC_ST      = 6'h2a;
    localparam logic [5:0]  OPC_SW      = 6'h2b;
    localparam logic [5:0]  FN_MFH      = 6'h10;
    localparam logic [5:0]  FN_MFL      = 6'h12;
    localparam logic [5:0]  FN_MULT     = 6'h18;
    localparam logic [5:0]  FN_MULTU    = 6'h19;

    typedef enum logic [1:0]
    {
        FMT_IMM = 2'b00,
        FMT_JMP = 2'b01,
        FMT_REG = 2'b10
    } fmt_t;

    typedef enum logic [1:0]
    {
        SZ_BYTE   = 2'b00,
        SZ_HALF   = 2'b01,
        SZ_TRIPLE = 2'b10,
        SZ_WORD   = 2'b11
    } size_t;

    typedef struct packed
    {
        fmt_t        fmt;
        logic [5:0]  operation_code_field;
        logic [4:0]  source_reg_select;
        logic [4:0]  target_reg_select;
        logic [4:0]  dest_reg_select;
        logic [4:0]  shift_amount_field;
        logic [5:0]  function_field;
        logic [15:0] immediate_field;
        logic [25:0] jump_target_field;
    } fields_t;

    typedef struct packed
    {
        logic        valid;
        logic        is_store;
        size_t       size;
        logic [31:0] addr;
        logic [3:0]  lanes;
        logic        addr_error;
    } mem_req_t;

endpackage : instr_decode_pkg

// file: design/instr_format_decode_lanes.sv
/*
  Decode stage: splits instruction words into fields, forms load and store addresses and
  byte lanes, and holds the pipeline for load-use and product-read hazards.
  Assumes the fetch stage holds its word while stall_out is high, and that the register
  file supplies the base value in the same cycle as the word.
*/
`timescale 1ns/100ps
`default_nettype none
module instr_format_decode_lanes #(
    parameter int MUL_LATENCY = instr_decode_pkg::MUL_LAT_DEF
) (
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_in,
    input  wire logic                        big_endian_in,
    input  wire logic                        instr_valid_in,
    input  wire logic [31:0]                 instr_in,
    input  wire logic [31:0]                 instr_addr_in,
    input  wire logic [31:0]                 base_value_in,
    output var  instr_decode_pkg::fields_t   fields_out,
    output var  instr_decode_pkg::mem_req_t  mem_req_out,
    output logic                             fetch_misaligned_out,
    output logic                             mul_start_out,
    output logic                             stall_out
);

    localparam logic [3:0] MUL_CNT = 4'(MUL_LATENCY);

    // Lane mask in little-endian bit order; mirrored for big endian.
    function automatic logic [4:0] lane_map(input instr_decode_pkg::size_t sz,
                                            input logic [2:0] lo);
        logic [4:0] r;
        r = 5'h10;
        unique case (sz)
            instr_decode_pkg::SZ_WORD:   if (lo == 3'h0) r = 5'h0f;
            instr_decode_pkg::SZ_TRIPLE: if (lo == 3'h0) r = 5'h07;
                                         else if (lo == 3'h1) r = 5'h0e;
            instr_decode_pkg::SZ_HALF:   if (lo == 3'h0) r = 5'h03;
                                         else if (lo == 3'h2) r = 5'h0c;
            instr_decode_pkg::SZ_BYTE:   if (lo[2] == 1'b0) r = {1'b0, 4'h1 << lo[1:0]};
        endcase
        return r;
    endfunction : lane_map

    instr_decode_pkg::fields_t f;
    logic                      is_load;
    logic                      is_store;
    instr_decode_pkg::size_t   sz;
    logic [31:0]               ea;
    logic [4:0]                lm;
    logic [3:0]                lanes_le;
    logic                      is_mul;
    logic                      is_mfp;
    logic                      load_use;
    logic                      prod_wait;
    logic                      accept;
    logic                      load_pend_r;
    logic [4:0]                load_reg_r;
    logic [3:0]                mul_cnt_r;

    // RQ2 format select
    always_comb
    begin
        f = '0;
        f.operation_code_field = instr_in[instr_decode_pkg::OPC_MSB:instr_decode_pkg::OPC_LSB];
        if (f.operation_code_field == instr_decode_pkg::OPC_SPECIAL)
            f.fmt = instr_decode_pkg::FMT_REG;
        else if (f.operation_code_field == instr_decode_pkg::OPC_JUMP ||
                 f.operation_code_field == instr_decode_pkg::OPC_JLINK)
            f.fmt = instr_decode_pkg::FMT_JMP;
        else
            f.fmt = instr_decode_pkg::FMT_IMM;
        // RQ3 source and target
        f.source_reg_select = instr_in[instr_decode_pkg::SRC_MSB:instr_decode_pkg::SRC_LSB];
        f.target_reg_select = instr_in[instr_decode_pkg::TGT_MSB:instr_decode_pkg::TGT_LSB];
        // RQ5 register fields
        f.dest_reg_select    = instr_in[instr_decode_pkg::DST_MSB:instr_decode_pkg::DST_LSB];
        f.shift_amount_field = instr_in[instr_decode_pkg::SHF_MSB:instr_decode_pkg::SHF_LSB];
        f.function_field     = instr_in[instr_decode_pkg::FUN_MSB:0];
        f.jump_target_field  = instr_in[instr_decode_pkg::JMP_MSB:0];
        // RQ4 RQ13 immediate operand
        f.immediate_field = instr_in[instr_decode_pkg::IMM_MSB:0];
        if (f.fmt == instr_decode_pkg::FMT_JMP)
        begin
            f.source_reg_select = '0;
            f.target_reg_select = '0;
        end
        if (f.fmt != instr_decode_pkg::FMT_REG)
        begin
            f.dest_reg_select    = '0;
            f.shift_amount_field = '0;
            f.function_field     = '0;
        end
        if (f.fmt != instr_decode_pkg::FMT_IMM)
            f.immediate_field = '0;
        if (f.fmt != instr_decode_pkg::FMT_JMP)
            f.jump_target_field = '0;
    end

    // RQ8 size from opcode
    always_comb
    begin
        is_load  = 1'b1;
        is_store = 1'b0;
        sz       = instr_decode_pkg::SZ_WORD;
        unique case (f.operation_code_field)
            instr_decode_pkg::OPC_LB: sz = instr_decode_pkg::SZ_BYTE;
            instr_decode_pkg::OPC_LH: sz = instr_decode_pkg::SZ_HALF;
            instr_decode_pkg::OPC_LT: sz = instr_decode_pkg::SZ_TRIPLE;
            instr_decode_pkg::OPC_LW: sz = instr_decode_pkg::SZ_WORD;
            instr_decode_pkg::OPC_SB: begin is_load = 1'b0; is_store = 1'b1;
                                      sz = instr_decode_pkg::SZ_BYTE; end
            instr_decode_pkg::OPC_SH: begin is_load = 1'b0; is_store = 1'b1;
                                      sz = instr_decode_pkg::SZ_HALF; end
            instr_decode_pkg::OPC_ST: begin is_load = 1'b0; is_store = 1'b1;
                                      sz = instr_decode_pkg::SZ_TRIPLE; end
            instr_decode_pkg::OPC_SW: begin is_load = 1'b0; is_store = 1'b1;
                                      sz = instr_decode_pkg::SZ_WORD; end
            default:                  is_load = 1'b0;
        endcase
    end

    // RQ6 base plus signed offset
    assign ea = base_value_in + {{16{f.immediate_field[15]}}, f.immediate_field};
    // RQ11 permitted lanes
    assign lm = lane_map(sz, ea[2:0]);
    // RQ9 RQ10 endian mirror
    assign lanes_le = big_endian_in ? {lm[0], lm[1], lm[2], lm[3]} : lm[3:0];

    assign is_mul = (f.fmt == instr_decode_pkg::FMT_REG) &&
                    (f.function_field == instr_decode_pkg::FN_MULT ||
                     f.function_field == instr_decode_pkg::FN_MULTU);
    assign is_mfp = (f.fmt == instr_decode_pkg::FMT_REG) &&
                    (f.function_field == instr_decode_pkg::FN_MFH ||
                     f.function_field == instr_decode_pkg::FN_MFL);

    // RQ7 load-use compare
    assign load_use = instr_valid_in && load_pend_r && (load_reg_r != 5'h00) &&
                      (load_reg_r == f.source_reg_select ||
                       (f.fmt != instr_decode_pkg::FMT_JMP && load_reg_r == f.target_reg_select));
    // RQ15 product wait
    assign prod_wait = instr_valid_in && is_mfp && (mul_cnt_r != 4'h0);
    assign accept    = instr_valid_in && !load_use && !prod_wait;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            load_pend_r <= 1'b0;
            load_reg_r  <= 5'h00;
        end
        else
        begin
            load_pend_r <= accept && is_load && !lm[4];
            load_reg_r  <= f.target_reg_select;
        end
    end

    // RQ14 multiplier busy count
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mul_cnt_r <= 4'h0;
        else if (accept && is_mul)
            mul_cnt_r <= MUL_CNT;
        else if (mul_cnt_r != 4'h0)
            mul_cnt_r <= mul_cnt_r - 4'h1;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fields_out           <= '0;
            mem_req_out          <= '0;
            fetch_misaligned_out <= 1'b0;
            mul_start_out        <= 1'b0;
            stall_out            <= 1'b0;
        end
        else
        begin
            stall_out     <= load_use || prod_wait;
            mul_start_out <= accept && is_mul;
            // RQ1 word alignment
            fetch_misaligned_out <= instr_valid_in &&
                                    (instr_addr_in[1:0] != instr_decode_pkg::ALIGN_BITS);
            if (accept)
                fields_out <= f;
            // RQ12 refused access carries no valid
            mem_req_out.valid    <= accept && (is_load || is_store) && !lm[4];
            mem_req_out.is_store <= is_store;
            mem_req_out.size     <= sz;
            mem_req_out.addr     <= ea;
            // RQ12 address error blocks lanes
            mem_req_out.lanes      <= lm[4] ? 4'h0 : lanes_le;
            mem_req_out.addr_error <= accept && (is_load || is_store) && lm[4];
        end
    end

    // RQ12
    AST_ADDR_ERR_NO_LANES: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        mem_req_out.addr_error |-> mem_req_out.lanes == 4'h0 && !mem_req_out.valid)
        else $error("address error with lanes set");
    // RQ11
    AST_WORD_ALIGNED_OK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (accept && is_load && sz == instr_decode_pkg::SZ_WORD && ea[2:0] == 3'h0)
        |=> mem_req_out.lanes == 4'hf && !mem_req_out.addr_error)
        else $error("aligned word refused");
    // RQ10
    AST_BE_BYTE0: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (accept && is_store && sz == instr_decode_pkg::SZ_BYTE && ea[2:0] == 3'h0 &&
         big_endian_in) |=> mem_req_out.lanes == 4'h8)
        else $error("big endian byte 0 lane wrong");
    // RQ7
    sequence s_load_then_use;
        accept && is_load && !lm[4] ##1 instr_valid_in && load_use;
    endsequence
    AST_LOAD_USE_STALL: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_load_then_use |=> stall_out && !mem_req_out.valid)
        else $error("load use not stalled");
    // RQ15
    AST_MFP_WAIT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (accept && is_mul) ##1 (instr_valid_in && is_mfp) |=> stall_out)
        else $error("product read not held");
    // RQ14
    AST_MUL_DRAINS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (accept && is_mul) |=> mul_start_out ##[0:15] (mul_cnt_r == 4'h0))
        else $error("multiplier never frees");
    // RQ6
    AST_EA_SUM: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (accept && is_load) |=> mem_req_out.addr ==
        $past(base_value_in) + {{16{$past(instr_in[15])}}, $past(instr_in[15:0])})
        else $error("effective address wrong");
    // RQ2
    AST_OPC_FIELD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        accept |=> fields_out.operation_code_field == $past(instr_in[31:26]))
        else $error("operation code field wrong");
    // RQ1
    AST_MISALIGN: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (instr_valid_in && instr_addr_in[0]) |=> fetch_misaligned_out)
        else $error("misaligned fetch missed");

endmodule : instr_format_decode_lanes
`default_nettype wire

// file: tb/fetch_model.sv
/*
  Fetch stage model: presents queued words and holds each one while stalled.
  Assumes the decoder's stall output is registered and is read just after the edge.
*/
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
    input  wire logic   clk_sys_in,
    input  wire logic   stall_in,
    output logic        valid_out,
    output logic [31:0] instr_out,
    output logic [31:0] addr_out,
    output logic [31:0] base_out,
    output logic        big_endian_out
);
    logic [96:0] pend[$];
    logic [96:0] taken_word;
    int          taken_cnt = 0;

    task automatic push(input logic [96:0] w);
        pend.push_back(w);
    endtask : push

    initial
    begin
        {big_endian_out, base_out, addr_out, instr_out} = '0;
        valid_out = 1'b0;
    end

    always @(posedge clk_sys_in)
    begin
        #1;
        if (valid_out && !stall_in)
        begin
            taken_cnt++;
            taken_word = {big_endian_out, base_out, addr_out, instr_out};
        end
        if (!valid_out || !stall_in)
        begin
            valid_out = pend.size() > 0;
            if (valid_out)
                {big_endian_out, base_out, addr_out, instr_out} = pend.pop_front();
            else
                {base_out, addr_out, instr_out} = ~{base_out, addr_out, instr_out};
        end
    end
endmodule : fetch_model
`default_nettype wire

// file: tb/tb_instr_format_decode_lanes.sv
/*
  Self-checking bench for the instruction format decoder.
  Assumes fetch_model presents the words and reports each word taken.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_instr_format_decode_lanes;
    localparam int MUL_LAT = 3;
    logic                       clk_sys_in;
    logic                       rst_in;
    logic                       valid;
    logic                       big_endian;
    logic [31:0]                instr;
    logic [31:0]                instr_addr;
    logic [31:0]                base_value;
    instr_decode_pkg::fields_t  fields;
    instr_decode_pkg::mem_req_t mem_req;
    logic                       misaligned;
    logic                       mul_start;
    logic                       stall;
    int                         errors = 0;
    int                         cmp_count = 0;
    int                         cycles = 0;
    int                         n;

    instr_format_decode_lanes #(.MUL_LATENCY(MUL_LAT)) uut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .big_endian_in(big_endian),
        .instr_valid_in(valid), .instr_in(instr), .instr_addr_in(instr_addr),
        .base_value_in(base_value), .fields_out(fields), .mem_req_out(mem_req),
        .fetch_misaligned_out(misaligned), .mul_start_out(mul_start), .stall_out(stall));
    fetch_model fetch (
        .clk_sys_in(clk_sys_in), .stall_in(stall), .valid_out(valid), .instr_out(instr),
        .addr_out(instr_addr), .base_out(base_value), .big_endian_out(big_endian));

    function automatic logic [31:0] r_w(input logic [4:0] rs, rt, rd, input logic [5:0] fn);
        return {6'h00, rs, rt, rd, 5'h03, fn};
    endfunction : r_w

    function automatic logic [31:0] i_w(input logic [5:0] op, input logic [4:0] rs, rt,
                                        input logic [15:0] imm);
        return {op, rs, rt, imm};
    endfunction : i_w

    function automatic instr_decode_pkg::fields_t exp_fields(input logic [31:0] w);
        instr_decode_pkg::fields_t f;
        f = '0;
        f.operation_code_field = w[31:26];
        f.fmt = instr_decode_pkg::FMT_IMM;
        if (w[31:27] == 5'h01)
        begin
            f.fmt = instr_decode_pkg::FMT_JMP;
            f.jump_target_field = w[25:0];
            return f;
        end
        f.source_reg_select = w[25:21];
        f.target_reg_select = w[20:16];
        if (w[31:26] != instr_decode_pkg::OPC_SPECIAL)
            f.immediate_field = w[15:0];
        else
        begin
            f.fmt = instr_decode_pkg::FMT_REG;
            f.dest_reg_select = w[15:11];
            f.shift_amount_field = w[10:6];
            f.function_field = w[5:0];
        end
        return f;
    endfunction : exp_fields

    function automatic instr_decode_pkg::mem_req_t exp_mem(input logic [96:0] t);
        instr_decode_pkg::mem_req_t m;
        int off;
        int sz;
        m = '0;
        if (t[31:30] == 2'b10 && t[28] == 1'b0)
        begin
            m.valid = 1'b1;
            m.is_store = t[29];
            m.size = instr_decode_pkg::size_t'(t[27:26]);
            m.addr = t[95:64] + {{16{t[15]}}, t[15:0]};
            off = int'(m.addr[2:0]);
            sz = int'(t[27:26]) + 1;
            m.addr_error = (off + sz > 4) || (sz == 2 && off % 2 == 1);
            m.valid = !m.addr_error;
            for (int b = off; b < off + sz && !m.addr_error; b++)
                m.lanes[t[96] ? 3 - b : b] = 1'b1;
        end
        return m;
    endfunction : exp_mem

    task automatic check(input string what, input logic [127:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give(input logic be, input logic [31:0] base, addr, w);
        fetch.push({be, base, addr, w});
    endtask : give

    task automatic run(input int words, output int stalls);
        int start;
        int prev;
        int guard;
        logic [96:0] t;
        instr_decode_pkg::mem_req_t m;
        instr_decode_pkg::mem_req_t s;
        start = fetch.taken_cnt;
        prev = start;
        stalls = 0;
        guard = 0;
        while (fetch.taken_cnt - start < words && guard < 4 * words + 20)
        begin
            @(posedge clk_sys_in);
            #2;
            guard++;
            stalls += int'(stall === 1'b1);
            if (fetch.taken_cnt == prev)
                check("mem_valid_idle", 128'(mem_req.valid), 128'h0);
            else
            begin
                t = fetch.taken_word;
                prev = fetch.taken_cnt;
                m = exp_mem(t);
                s = mem_req;
                check("fields", 128'(fields), 128'(exp_fields(t[31:0])));
                check("misaligned", 128'(misaligned), 128'(t[33:32] != 2'h0));
                check("mul_start", 128'(mul_start), 128'(t[31:26] == 6'h00 &&
                      t[5:1] == instr_decode_pkg::FN_MULT[5:1]));
                if (m.is_store || t[31:30] == 2'b10 && t[28] == 1'b0)
                    check("mem_req", 128'(s), 128'(m));
                else
                    check("mem_valid", 128'(mem_req.valid), 128'h0);
            end
        end
        check("taken_words", 128'(fetch.taken_cnt - start), 128'(words));
    endtask : run

    task automatic check_zero;
        check("reset_outputs", 128'({fields, mem_req, misaligned, mul_start, stall}), 128'h0);
    endtask : check_zero

    task automatic test_formats;
        give(1'b0, 32'h0, 32'h100, r_w(5'h11, 5'h0a, 5'h15, 6'h25));
        give(1'b0, 32'h0, 32'h104, {instr_decode_pkg::OPC_JUMP, 26'h2abcdef});
        give(1'b0, 32'h0, 32'h108, {instr_decode_pkg::OPC_JLINK, 26'h1543210});
        give(1'b0, 32'h0, 32'h10a, i_w(6'h08, 5'h1f, 5'h01, 16'h8001));
        give(1'b1, 32'h0, 32'h10c, i_w(6'h0d, 5'h02, 5'h1e, 16'h7ffe));
        run(5, n);
        $display("test_formats done");
    endtask : test_formats

    task automatic test_lanes;
        for (int k = 0; k < 128; k++)
            give(k[0], 32'h0001_0008, 32'h200,
                 i_w({2'b10, k[6], 1'b0, k[5:4]}, 5'h1e, 5'(k), {13'h1fff, k[3:1]}));
        run(128, n);
        $display("test_lanes done");
    endtask : test_lanes

    task automatic pair(input logic [31:0] a, b, input int exp);
        give(1'b0, 32'h1000, 32'h300, 32'h0);
        give(1'b0, 32'h1000, 32'h304, a);
        give(1'b0, 32'h1000, 32'h308, b);
        run(3, n);
        check("stall_cycles", 128'(n), 128'(exp));
    endtask : pair

    task automatic test_load_use;
        logic [31:0] ld;
        ld = i_w(instr_decode_pkg::OPC_LW, 5'h01, 5'h05, 16'h0008);
        pair(ld, r_w(5'h05, 5'h06, 5'h07, 6'h20), 1);
        pair(ld, i_w(6'h08, 5'h06, 5'h05, 16'h0001), 1);
        pair(i_w(instr_decode_pkg::OPC_LB, 5'h01, 5'h00, 16'h0), r_w(5'h0, 5'h0, 5'h7, 6'h20), 0);
        pair(ld, r_w(5'h06, 5'h07, 5'h08, 6'h20), 0);
        pair(i_w(instr_decode_pkg::OPC_SW, 5'h01, 5'h05, 16'h8), r_w(5'h05, 5'h05, 5'h7, 6'h20), 0);
        $display("test_load_use done");
    endtask : test_load_use

    task automatic test_mul;
        give(1'b0, 32'h0, 32'h400, r_w(5'h03, 5'h04, 5'h00, instr_decode_pkg::FN_MULT));
        give(1'b0, 32'h0, 32'h404, r_w(5'h00, 5'h00, 5'h09, instr_decode_pkg::FN_MFH));
        run(2, n);
        check("mfh_stall", 128'(n >= 1 && n <= MUL_LAT), 128'h1);
        give(1'b0, 32'h0, 32'h408, r_w(5'h03, 5'h04, 5'h00, instr_decode_pkg::FN_MULTU));
        run(1, n);
        repeat (MUL_LAT + 2) @(posedge clk_sys_in);
        give(1'b0, 32'h0, 32'h40c, r_w(5'h00, 5'h00, 5'h0a, instr_decode_pkg::FN_MFL));
        run(1, n);
        check("mfl_late_stall", 128'(n), 128'h0);
        give(1'b0, 32'h0, 32'h410, r_w(5'h03, 5'h04, 5'h00, instr_decode_pkg::FN_MULT));
        give(1'b0, 32'h0, 32'h414, r_w(5'h03, 5'h04, 5'h0b, 6'h20));
        run(2, n);
        check("mul_overlap_stall", 128'(n), 128'h0);
        $display("test_mul done");
    endtask : test_mul

    task automatic test_mid_reset;
        give(1'b1, 32'h1000, 32'h500, i_w(instr_decode_pkg::OPC_LW, 5'h01, 5'h05, 16'h8));
        run(1, n);
        @(posedge clk_sys_in);
        #1;
        rst_in = 1'b1;
        #1;
        check_zero();
        repeat (2) @(posedge clk_sys_in);
        #1;
        rst_in = 1'b0;
        pair(32'h0, r_w(5'h05, 5'h05, 5'h06, 6'h20), 0);
        $display("test_mid_reset done");
    endtask : test_mid_reset

    task automatic results;
        $display("Counts: %0d comparisons, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    initial
    begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    initial
    begin
        rst_in = 1'b1;
        repeat (20) @(posedge clk_sys_in);
        #1;
        check_zero();
        rst_in = 1'b0;
        test_formats();
        test_lanes();
        test_load_use();
        test_mul();
        test_mid_reset();
        results();
    end

    // Stops a hung run and reports it as a mismatch.
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            results();
        end
    end
endmodule : tb_instr_format_decode_lanes
`default_nettype wire
